// [dv/tss_bus_master.sv]
// Purpose: Bus master model for the sensor's two-wire port
// Assumes: SDA is open drain with a pull-up; sda_wire is the wire level
// Notes: SCL stands high between frames; each phase lasts HALF clocks
module tss_bus_master #(
	parameter int HALF = 4
) (
	input wire logic clk_sys,
	input wire logic sda_wire,
	output logic scl_pin,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	initial scl_pin = 1'b1;
	initial sda_drv = 1'b1;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Start or repeated start: SDA falls while SCL is high
	task automatic start();
		sda_drv <= 1'b1;
		tick(HALF);
		scl_pin <= 1'b1;
		tick(HALF);
		sda_drv <= 1'b0;
		tick(HALF);
		scl_pin <= 1'b0;
		tick(1);
	endtask

	task automatic stop();
		sda_drv <= 1'b0;
		tick(HALF);
		scl_pin <= 1'b1;
		tick(HALF);
		sda_drv <= 1'b1;
		tick(HALF);
	endtask

	// Data moves one clock after SCL falls, so no false start is seen
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		tick(HALF);
		scl_pin <= 1'b1;
		tick(HALF);
		r = sda_wire;
		scl_pin <= 1'b0;
		tick(1);
	endtask

	// Stall holds SCL low before the ack clock
	task automatic wr_byte(input logic [7:0] d, input int stall,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		tick(stall);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask

	// Write byte or word: address, command, data bytes MSB first
	task automatic wr(input logic [6:0] a, input logic [7:0] p,
		input int n, input logic [15:0] d, output logic ok);
		logic k;
		start();
		wr_byte({a, 1'b0}, 0, ok);
		wr_byte(p, 0, k);
		ok &= k;
		for (int i = n - 1; i >= 0; i--) begin
			wr_byte(d[8*i+:8], 0, k);
			ok &= k;
		end
		stop();
	endtask

	// Read byte or word; last byte answered with a NACK
	task automatic rd(input logic [6:0] a, input logic [7:0] p,
		input logic setp, input int n, output logic [15:0] d,
		output logic ok);
		logic k;
		logic [7:0] b;
		d = 16'h0000;
		ok = 1'b1;
		start();
		if (setp) begin
			wr_byte({a, 1'b0}, 0, k);
			ok = k;
			wr_byte(p, 0, k);
			ok &= k;
			start();
		end
		wr_byte({a, 1'b1}, 0, k);
		ok &= k;
		for (int i = n - 1; i >= 0; i--) begin
			rd_byte(i == 0, b);
			d[8*i+:8] = b;
		end
		stop();
	endtask
endmodule

// [dv/tss_sensor_tb.sv]
// Purpose: Self-checking bench for the sensor front end
// Assumes: Short timeout and conversion counts set at the instance
// Notes: Expectations built from pointer map and result layout
`include "tss_map.svh"

module tss_sensor_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] ADDR = 7'h4A;
	// Alarm variant has two straps, so only straps[1:0] count
	localparam logic [6:0] ADDR2 = 7'h42;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] straps;
	logic [12:0] adc_code;
	logic [1:0] flags;
	logic scl_pin;
	logic sda_drv;
	logic sda_wire;
	logic sda_pin_out;
	logic sda_pin_oe;
	logic [7:0] cfg_value;
	logic sda2_out;
	logic sda2_oe;
	logic [7:0] cfg2;
	logic ok;
	logic [15:0] rdat;
	int err_count = 0;
	int cmp_count = 0;

	always #12.5 clk_sys = ~clk_sys;

	// Wire level: any slave pull-down wins over the pull-up
	assign sda_wire = sda_drv & (sda_pin_oe ? sda_pin_out : 1'b1) &
		(sda2_oe ? sda2_out : 1'b1);

	tss_sensor #(.TIMEOUT_CYC(200), .CONV_CYC(500)) i_dut (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.scl_pin(scl_pin),
		.sda_pin_in(sda_wire),
		.sda_pin_out(sda_pin_out),
		.sda_pin_oe(sda_pin_oe),
		.addr_strap_bit0(straps[0]),
		.addr_strap_bit1(straps[1]),
		.addr_strap_bit2(straps[2]),
		.addr_strap_bit3(straps[3]),
		.adc_code(adc_code),
		.alarm_flags(flags),
		.cfg_value(cfg_value)
	);

	// Second slave on the same wires: alarm variant, two straps
	tss_sensor #(.ADDR_PINS(2), .ALARM_OUTS(1), .TIMEOUT_CYC(200),
		.CONV_CYC(500)) i_dut_alm (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.scl_pin(scl_pin),
		.sda_pin_in(sda_wire),
		.sda_pin_out(sda2_out),
		.sda_pin_oe(sda2_oe),
		.addr_strap_bit0(straps[0]),
		.addr_strap_bit1(straps[1]),
		.addr_strap_bit2(straps[2]),
		.addr_strap_bit3(straps[3]),
		.adc_code(adc_code),
		.alarm_flags(flags),
		.cfg_value(cfg2)
	);

	tss_bus_master i_master (
		.clk_sys(clk_sys),
		.sda_wire(sda_wire),
		.scl_pin(scl_pin),
		.sda_drv(sda_drv)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wcfg(input logic [7:0] v);
		i_master.wr(ADDR, `TSS_PTR_CFG, 1, {8'h00, v}, ok);
	endtask

	task automatic rtemp(input logic setp);
		i_master.rd(ADDR, `TSS_PTR_TEMP, setp, 2, rdat, ok);
	endtask

	task automatic t_reset();
		chk(cfg_value, 8'h00, "cfg reset");
		i_master.rd(ADDR, `TSS_PTR_CFG, 1'b1, 1, rdat, ok);
		chk(rdat, 16'h0000, "cfg read");
		$display("test reset done");
	endtask

	task automatic t_cfg();
		wcfg(8'h91);
		chk(ok, 1'b1, "byte write acks");
		chk(cfg_value, 8'h91, "cfg port");
		i_master.rd(ADDR, `TSS_PTR_CFG, 1'b1, 1, rdat, ok);
		chk(rdat, 16'h0091, "read byte");
		i_master.rd(ADDR, `TSS_PTR_CFG, 1'b1, 2, rdat, ok);
		chk(rdat, 16'h9100, "read word");
		i_master.wr(ADDR, `TSS_PTR_CFG, 2, 16'h1234, ok);
		chk(cfg_value, 8'h12, "write word");
		wcfg(8'h00);
		$display("test cfg done");
	endtask

	task automatic t_addr();
		i_master.wr(7'h4B, `TSS_PTR_CFG, 1, 16'h00FF, ok);
		chk(ok, 1'b0, "foreign addr");
		chk(cfg_value, 8'h00, "foreign write");
		straps <= 4'h5;
		i_master.tick(10);
		i_master.wr(7'h45, `TSS_PTR_CFG, 1, 16'h0042, ok);
		chk(ok, 1'b1, "strap addr");
		chk(cfg_value, 8'h42, "strap write");
		straps <= 4'hA;
		i_master.tick(10);
		wcfg(8'h00);
		$display("test addr done");
	endtask

	// Status flags move too; the basic variant must keep them out
	task automatic t_temp();
		logic [12:0] codes [2] = '{13'h1F38, 13'h0190};
		foreach (codes[i]) begin
			adc_code <= codes[i];
			flags <= 2'(i + 1);
			i_master.tick(1200);
			rtemp(1'b1);
			chk(rdat, {codes[i], 3'b000}, "temp word");
		end
		$display("test temp done");
	endtask

	// Read restarts the period, so a quick second read sees the old code
	task automatic t_abort();
		rtemp(1'b1);
		adc_code <= 13'h0AAA;
		rtemp(1'b0);
		chk(rdat, 16'h0C80, "after abort");
		i_master.tick(700);
		rtemp(1'b0);
		chk(rdat, 16'h5550, "next result");
		$display("test abort done");
	endtask

	task automatic t_shdn();
		wcfg(8'h01);
		adc_code <= 13'h0123;
		i_master.tick(1200);
		rtemp(1'b1);
		chk(rdat, 16'h5550, "shutdown hold");
		wcfg(8'h00);
		i_master.tick(1200);
		rtemp(1'b1);
		chk(rdat, 16'h0918, "resumed");
		$display("test shutdown done");
	endtask

	task automatic t_tmo();
		logic [7:0] v [2] = '{8'h00, 8'h80};
		foreach (v[i]) begin
			wcfg(v[i]);
			i_master.start();
			i_master.wr_byte({ADDR, 1'b0}, 300, ok);
			i_master.stop();
			chk(ok, v[i][7], "ack after stall");
		end
		wcfg(8'h00);
		$display("test timeout done");
	endtask

	task automatic t_ptr();
		i_master.wr(ADDR, 8'h05, 1, 16'h00AA, ok);
		i_master.rd(ADDR, 8'h05, 1'b1, 1, rdat, ok);
		chk(rdat, 16'h0000, "bad pointer");
		chk(cfg_value, 8'h00, "cfg untouched");
		$display("test pointer done");
	endtask

	// Alarm variant: status bits in the result, threshold words kept
	task automatic t_alarm();
		flags <= 2'b10;
		i_master.tick(1200);
		i_master.rd(ADDR2, `TSS_PTR_TEMP, 1'b1, 2, rdat, ok);
		chk(ok, 1'b1, "two strap addr");
		chk(rdat, {13'h0123, 1'b0, 2'b10}, "status bits");
		i_master.wr(ADDR2, `TSS_PTR_HIGH, 2, 16'h1A2B, ok);
		i_master.rd(ADDR2, `TSS_PTR_HIGH, 1'b1, 2, rdat, ok);
		chk(rdat, 16'h1A2B, "high word");
		i_master.wr(ADDR2, `TSS_PTR_HYST, 2, 16'hC3D4, ok);
		i_master.rd(ADDR2, `TSS_PTR_HYST, 1'b1, 2, rdat, ok);
		chk(rdat, 16'hC3D4, "hysteresis word");
		i_master.wr(ADDR2, `TSS_PTR_LOW, 1, 16'h0077, ok);
		i_master.rd(ADDR2, `TSS_PTR_LOW, 1'b1, 2, rdat, ok);
		chk(rdat, 16'h0000, "low half word");
		i_master.rd(ADDR, `TSS_PTR_HIGH, 1'b1, 2, rdat, ok);
		chk(rdat, 16'h0000, "no thresholds");
		chk(cfg2, 8'h00, "other cfg");
		$display("test alarm done");
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clk_sys);
		err_count++;
		report_and_stop();
	end

	initial begin
		straps <= 4'hA;
		adc_code <= 13'h0000;
		flags <= 2'b00;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		t_reset();
		t_cfg();
		t_addr();
		t_temp();
		t_abort();
		t_shdn();
		t_tmo();
		t_ptr();
		t_alarm();
		report_and_stop();
	end
endmodule

// [hdl/tss_conv.sv]
// Purpose: Back-to-back conversion sequencer holding the latest result
// Assumes: adc_code is stable on clk_sys
// Notes: Shutdown freezes sequencing but keeps the last result
`include "tss_map.svh"

module tss_conv #(
	parameter int CONV_CYC = `TSS_CONV_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [12:0] adc_code,
	tss_conv_if.conv cv
);

	logic [31:0] cnt_q, cnt_d;
	logic done_q, done_d;
	logic [12:0] code_q, code_d;
	logic last;

	assign last = (cnt_q == 32'(CONV_CYC - 1));

	// Sequencer: a read abort restarts the running conversion
	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		code_d = code_q;
		if (cv.abort || cv.shutdown) begin
			cnt_d = '0;
		end else if (last) begin
			cnt_d = '0;
			done_d = 1'b1;
			code_d = adc_code;
		end else begin
			cnt_d = cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
			done_q <= 1'b0;
			code_q <= 13'h0000;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
			code_q <= code_d;
		end
	end

	assign cv.done = done_q;
	assign cv.code = code_q;

	chk_conv_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
		last && !cv.abort && !cv.shutdown |=> done_q && cnt_q == 32'h0)
		else $error("conversion did not complete at period end");
	chk_abort_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cv.abort |=> cnt_q == 32'h0 && !done_q)
		else $error("abort did not restart conversion");

endmodule

// [hdl/tss_conv_if.sv]
// Purpose: Link between the serial front end and the conversion sequencer
// Assumes: One clock domain
// Notes: Abort is a one-cycle pulse
interface tss_conv_if;
	logic abort;
	logic shutdown;
	logic done;
	logic [12:0] code;

	modport ctrl (output abort, output shutdown, input done, input code);
	modport conv (input abort, input shutdown, output done, output code);
endinterface

// [hdl/tss_map.svh]
// Purpose: Register pointers, field positions, reset values and timing counts
// Assumes: Included by bare name; clk_sys runs at 40 MHz
// Notes: Definitions only
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH

// Pointer values selecting a register
`define TSS_PTR_TEMP 8'h00
`define TSS_PTR_CFG 8'h01
`define TSS_PTR_HYST 8'h02
`define TSS_PTR_LOW 8'h03
`define TSS_PTR_HIGH 8'h04

// Configuration field positions
`define TSS_CFG_SHDN 0
`define TSS_CFG_FQ_EN 4
`define TSS_CFG_TO_DIS 7

// Reset values
`define TSS_CFG_RST 8'h00
`define TSS_THR_RST 16'h0000

// Fixed upper address bits (strapped pins replace the low ones)
`define TSS_ADDR_FIXED 7'h40

// Timing: times in their own unit, cycles derived from the clock rate
`define TSS_CLK_KHZ 40000
`define TSS_TIMEOUT_MS 25
`define TSS_CONV_MS 500
`define TSS_TIMEOUT_CYC (`TSS_TIMEOUT_MS * `TSS_CLK_KHZ)
`define TSS_CONV_CYC (`TSS_CONV_MS * `TSS_CLK_KHZ)

`endif

// [hdl/tss_pkg.sv]
// Purpose: Types shared by the sensor front end
// Assumes: Nothing imported; used as tss_pkg::name
// Notes: Gray codes follow the path of a write transfer; ST_ACK_ADDR to ST_RDATA changes three bits
package tss_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK_ADDR = 4'h3,
		ST_CMD = 4'h2,
		ST_ACK_CMD = 4'h6,
		ST_WDATA = 4'h7,
		ST_ACK_WDATA = 4'h5,
		ST_RDATA = 4'h4,
		ST_RACK = 4'hC
	} tss_state_type;

endpackage

// [hdl/tss_sensor.sv]
// Purpose: Two-wire slave and register front end of a temperature sensor
// Assumes: scl/sda/straps asynchronous to clk_sys; adc_code on clk_sys
// Notes: ALARM_OUTS 0 or 1 selects the low status bits and thresholds
// Behaviour
// - Slave only; handles write byte, write word, read byte, read word.
// - Slave address low bits come from strap pins, one bit each.
// - Two, three or four strap pins give 4, 8 or 16 addresses.
// - Command byte loads pointer selecting the register later accessed.
// - Temperature register holds latest result, 12 bits plus sign.
// - Result is 16 bits; low three bits unused without alarm output.
// - Two's-complement Celsius, one LSB equals 0.0625 degrees.
// - With one alarm output, two low bits are status, bit two unused.
// - With one alarm output, pointer selects among five registers.
// - Eight-bit configuration register is writable and reads back.
// - Config holds timeout disable, fault queue, shutdown; timeout 25-48ms.
// - Conversion runs continuously; result readable at any time.
// - Byte write: address, command, data; each byte acknowledged.
// - Conversions run back to back, each about 500 ms.
// - Reading the temperature register aborts the running conversion.
`include "tss_map.svh"

module tss_sensor #(
	parameter int ADDR_PINS = 4,
	parameter int ALARM_OUTS = 0,
	parameter logic [6:0] ADDR_FIXED = `TSS_ADDR_FIXED,
	parameter int TIMEOUT_CYC = `TSS_TIMEOUT_CYC,
	parameter int CONV_CYC = `TSS_CONV_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_pin_out,
	output logic sda_pin_oe,
	input wire logic addr_strap_bit0,
	input wire logic addr_strap_bit1,
	input wire logic addr_strap_bit2,
	input wire logic addr_strap_bit3,
	input wire logic [12:0] adc_code,
	input wire logic [1:0] alarm_flags,
	output logic [7:0] cfg_value
);

	tss_conv_if cv ();

	tss_conv #(.CONV_CYC(CONV_CYC)) u_conv (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.adc_code(adc_code),
		.cv(cv)
	);

	// Pin synchronisers; stage one feeds only stage two
	// Layout: [7:6] alarm flags, [5:2] straps, [1] scl, [0] sda
	logic [7:0] s1_q, s2_q;
	logic scl_d1_q, sda_d1_q;
	logic [3:0] strap_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q <= 8'h03; // Bus lines idle high, no false edge
			s2_q <= 8'h03;
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
			strap_q <= 4'h0;
		end else begin
			s1_q <= {alarm_flags, addr_strap_bit3, addr_strap_bit2,
				addr_strap_bit1, addr_strap_bit0, scl_pin, sda_pin_in};
			s2_q <= s1_q;
			scl_d1_q <= s2_q[1];
			sda_d1_q <= s2_q[0];
			strap_q <= s2_q[5:2];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	assign scl_s = s2_q[1];
	assign sda_s = s2_q[0];
	assign scl_rise = scl_s && !scl_d1_q;
	assign scl_fall = !scl_s && scl_d1_q;
	assign start_c = scl_s && scl_d1_q && !sda_s && sda_d1_q;
	assign stop_c = scl_s && scl_d1_q && sda_s && !sda_d1_q;

	// Own address: fixed bits above, strap levels below
	logic [6:0] my_addr;
	always_comb begin
		my_addr = ADDR_FIXED;
		for (int i = 0; i < ADDR_PINS; i++) begin
			my_addr[i] = strap_q[i];
		end
	end

	// Bus timeout: a stuck low clock mid-transfer frees the slave
	logic [31:0] tmo_q, tmo_d;
	logic tmo_fire;
	logic [7:0] cfg_q, cfg_d;
	tss_pkg::tss_state_type st_q, st_d;
	assign tmo_fire = (tmo_q == 32'(TIMEOUT_CYC - 1)) &&
		!cfg_q[`TSS_CFG_TO_DIS];
	always_comb begin
		tmo_d = '0;
		if (st_q != tss_pkg::ST_IDLE && !scl_s && !tmo_fire) begin
			tmo_d = tmo_q + 32'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tmo_q <= '0;
		end else begin
			tmo_q <= tmo_d;
		end
	end

	// Register word seen by a read; unmapped pointers read zero
	logic [15:0] hi_q, hi_d, lo_q, lo_d, hyst_q, hyst_d, temp_word, word_sel;
	logic [7:0] ptr_q, ptr_d;
	assign temp_word = (ALARM_OUTS == 0) ? {cv.code, 3'b000} :
		{cv.code, 1'b0, s2_q[7:6]};
	always_comb begin
		word_sel = 16'h0000;
		case (ptr_q)
			`TSS_PTR_TEMP: word_sel = temp_word;
			`TSS_PTR_CFG: word_sel = {cfg_q, 8'h00};
			`TSS_PTR_HIGH: word_sel = (ALARM_OUTS > 0) ? hi_q : 16'h0000;
			`TSS_PTR_LOW: word_sel = (ALARM_OUTS > 0) ? lo_q : 16'h0000;
			`TSS_PTR_HYST: word_sel = (ALARM_OUTS > 0) ? hyst_q : 16'h0000;
			default: word_sel = 16'h0000;
		endcase
	end

	// Transfer engine: sample on SCL rise, change SDA on SCL fall
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, hold_q, hold_d;
	logic [15:0] tx_q, tx_d;
	logic oe_q, oe_d, rw_q, rw_d, nack_q, nack_d, abort_q, abort_d;
	logic [1:0] bidx_q, bidx_d;
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		oe_d = oe_q;
		rw_d = rw_q;
		nack_d = nack_q;
		ptr_d = ptr_q;
		hold_d = hold_q;
		bidx_d = bidx_q;
		cfg_d = cfg_q;
		hi_d = hi_q;
		lo_d = lo_q;
		hyst_d = hyst_q;
		abort_d = 1'b0;
		if (start_c) begin
			st_d = tss_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_c || tmo_fire) begin
			st_d = tss_pkg::ST_IDLE;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			case (st_q)
				tss_pkg::ST_ADDR, tss_pkg::ST_CMD, tss_pkg::ST_WDATA: begin
					sh_d = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end
				tss_pkg::ST_RDATA: cnt_d = cnt_q + 4'h1;
				tss_pkg::ST_RACK: nack_d = sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_q)
				tss_pkg::ST_ADDR: begin
					if (cnt_q == 4'h8) begin
						if (sh_q[7:1] == my_addr) begin
							st_d = tss_pkg::ST_ACK_ADDR;
							oe_d = 1'b1;
							rw_d = sh_q[0];
						end else begin
							st_d = tss_pkg::ST_IDLE;
						end
					end
				end
				tss_pkg::ST_ACK_ADDR: begin
					cnt_d = 4'h0;
					bidx_d = 2'h0;
					if (rw_q) begin
						st_d = tss_pkg::ST_RDATA;
						tx_d = word_sel;
						oe_d = !word_sel[15];
						abort_d = (ptr_q == `TSS_PTR_TEMP);
					end else begin
						st_d = tss_pkg::ST_CMD;
						oe_d = 1'b0;
					end
				end
				tss_pkg::ST_CMD: begin
					if (cnt_q == 4'h8) begin
						ptr_d = sh_q;
						st_d = tss_pkg::ST_ACK_CMD;
						oe_d = 1'b1;
					end
				end
				tss_pkg::ST_ACK_CMD, tss_pkg::ST_ACK_WDATA: begin
					st_d = tss_pkg::ST_WDATA;
					oe_d = 1'b0;
					cnt_d = 4'h0;
				end
				tss_pkg::ST_WDATA: begin
					if (cnt_q == 4'h8) begin
						st_d = tss_pkg::ST_ACK_WDATA;
						oe_d = 1'b1;
						if (bidx_q != 2'h3) begin
							bidx_d = bidx_q + 2'h1;
						end
						if (bidx_q == 2'h0) begin
							hold_d = sh_q;
							if (ptr_q == `TSS_PTR_CFG) begin
								cfg_d = sh_q;
							end
						end else if (bidx_q == 2'h1 && ALARM_OUTS > 0) begin
							case (ptr_q)
								`TSS_PTR_HIGH: hi_d = {hold_q, sh_q};
								`TSS_PTR_LOW: lo_d = {hold_q, sh_q};
								`TSS_PTR_HYST: hyst_d = {hold_q, sh_q};
								default: ;
							endcase
						end
					end
				end
				tss_pkg::ST_RDATA: begin
					if (cnt_q == 4'h8) begin
						st_d = tss_pkg::ST_RACK;
						oe_d = 1'b0;
					end else begin
						tx_d = {tx_q[14:0], 1'b0};
						oe_d = !tx_q[14];
					end
				end
				tss_pkg::ST_RACK: begin
					if (nack_q) begin
						st_d = tss_pkg::ST_IDLE;
					end else begin
						st_d = tss_pkg::ST_RDATA;
						cnt_d = 4'h0;
						tx_d = {tx_q[14:0], 1'b0};
						oe_d = !tx_q[14];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= tss_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 16'h0000;
			oe_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			ptr_q <= `TSS_PTR_TEMP;
			hold_q <= 8'h00;
			bidx_q <= 2'h0;
			cfg_q <= `TSS_CFG_RST;
			hi_q <= `TSS_THR_RST;
			lo_q <= `TSS_THR_RST;
			hyst_q <= `TSS_THR_RST;
			abort_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			oe_q <= oe_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			ptr_q <= ptr_d;
			hold_q <= hold_d;
			bidx_q <= bidx_d;
			cfg_q <= cfg_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			hyst_q <= hyst_d;
			abort_q <= abort_d;
		end
	end

	// Open drain: only ever pulls low
	assign sda_pin_out = 1'b0;
	assign sda_pin_oe = oe_q;
	assign cfg_value = cfg_q;
	assign cv.abort = abort_q;
	assign cv.shutdown = cfg_q[`TSS_CFG_SHDN];

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	logic quiet;
	assign quiet = !start_c && !stop_c && !tmo_fire;

	chk_addr_ack: assert property (st_q == tss_pkg::ST_ADDR && scl_fall &&
		quiet && cnt_q == 4'h8 && sh_q[7:1] == my_addr
		|=> oe_q && st_q == tss_pkg::ST_ACK_ADDR)
		else $error("own address not acknowledged");
	chk_addr_ignore: assert property (st_q == tss_pkg::ST_ADDR && scl_fall &&
		quiet && cnt_q == 4'h8 && sh_q[7:1] != my_addr
		|=> !oe_q && st_q == tss_pkg::ST_IDLE)
		else $error("foreign address not ignored");
	chk_ptr_load: assert property (st_q == tss_pkg::ST_CMD && scl_fall &&
		quiet && cnt_q == 4'h8 |=> ptr_q == $past(sh_q) && oe_q)
		else $error("pointer not loaded from command byte");
	chk_cfg_write: assert property (st_q == tss_pkg::ST_WDATA && scl_fall &&
		quiet && cnt_q == 4'h8 && bidx_q == 2'h0 && ptr_q == `TSS_PTR_CFG
		|=> cfg_value == $past(sh_q) ##1 cfg_value == $past(sh_q, 2))
		else $error("configuration write lost");
	chk_temp_abort: assert property (st_q == tss_pkg::ST_ACK_ADDR &&
		scl_fall && quiet && rw_q && ptr_q == `TSS_PTR_TEMP
		|=> abort_q ##1 !abort_q)
		else $error("temperature read did not abort conversion");
	chk_msb_first: assert property ($past(st_q) == tss_pkg::ST_ACK_ADDR &&
		st_q == tss_pkg::ST_RDATA |-> oe_q == !tx_q[15])
		else $error("read did not start with MSB");
	chk_timeout_free: assert property (tmo_fire && !start_c
		|=> st_q == tss_pkg::ST_IDLE && !oe_q)
		else $error("timeout did not free the bus");
	chk_temp_layout: assert property (ALARM_OUTS == 0 |->
		temp_word == {cv.code, 3'b000})
		else $error("temperature layout wrong");

	cov_cfg_write: cover property (st_q == tss_pkg::ST_WDATA && scl_fall &&
		cnt_q == 4'h8 && ptr_q == `TSS_PTR_CFG);
	cov_word_read: cover property (st_q == tss_pkg::ST_RACK && scl_fall &&
		!nack_q ##[1:400] st_q == tss_pkg::ST_RACK && scl_fall && nack_q);
	cov_timeout: cover property (tmo_fire);
	cov_conv_done: cover property (cv.done);

endmodule
